// File: ltat_chk.sv
`timescale 1ns/1ps
`include "ltat_regs.vh"
// ************
// Acquisition timing checks
// ************
module ltat_chk (
    input logic                   i_clk,
    input logic                   i_rst_n,
    input logic                   i_variant,
    input logic                   i_ext_trigger,
    input logic [`LTAT_DLY_W-1:0] i_acquisition_delay_time,
    input logic                   o_trigger_event,
    input logic                   o_busy,
    input logic                   o_integrating,
    input logic                   o_single_strobe,
    input logic                   o_cont_strobe,
    input logic                   o_pulse_error,
    input logic                   o_zero_spectrum,
    input logic                   o_acq_done,
    input logic [`LTAT_CNT_W-1:0] o_level_pulse_width
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [`LTAT_CNT_W-1:0] min_w;
    assign min_w = i_variant ? 24'h001c20 : 24'h000ed8;
    trig_event_a: assert property ($rose(i_ext_trigger) && !o_busy |=> o_trigger_event)
        else $error("trigger event missing");
    integ_end_a: assert property (o_integrating && !i_ext_trigger |=> !o_integrating)
        else $error("integration outlived trigger");
    integ_hold_a: assert property (o_integrating && i_ext_trigger |=> o_integrating)
        else $error("integration cut short");
    strobe_idle_a: assert property (!o_integrating |-> !o_single_strobe && !o_cont_strobe)
        else $error("strobe high outside integration");
    busy_start_a: assert property (o_trigger_event |-> o_busy && !o_integrating)
        else $error("busy missing at event");
    busy_one_a: assert property (o_trigger_event && i_variant && i_acquisition_delay_time == 19'h0
        |-> ##[55:65] $rose(o_integrating)) else $error("initial busy length wrong");
    short_err_a: assert property ($fell(o_integrating) && o_level_pulse_width < min_w
        |-> o_pulse_error && o_zero_spectrum) else $error("short pulse not flagged");
    done_end_a: assert property ($fell(o_busy) |-> o_acq_done && !o_integrating)
        else $error("busy ended without done");
    cover property (o_trigger_event);
    cover property (o_single_strobe);
    cover property (o_pulse_error);
    cover property (o_acq_done);
endmodule

// File: ltat_core.v
`timescale 1ns/1ps
`include "ltat_regs.vh"

// Contract
// - Integration runs from the end of the first busy interval until the trigger input goes low, ignoring any set integration time.
// - A trigger event is registered one 100 ns cycle after the rising edge is seen.
// - Integration start is delayed by a programmable 0 to 335500 us delay in 1 us steps; the 19-bit input is not clamped, so up to 524287 us is accepted.
// - Single strobe rises after a set delay, stays high a set width, and drops when integration ends.
// - Continuous strobe toggles at a set period during integration and is forced low at its end.
// - A fixed busy interval precedes integration and another follows it before completion.
// - A pulse shorter than the minimum width flags an error and the spectrum is zeroed.
module ltat_core (
    input  wire                    i_clk,
    input  wire                    i_rst_n,
    input  wire                    i_ce,
    input  wire                    i_variant,
    input  wire                    i_ext_trigger,
    input  wire [`LTAT_DLY_W-1:0]  i_acquisition_delay_time,
    input  wire [`LTAT_CNT_W-1:0]  i_one_shot_strobe_delay,
    input  wire [`LTAT_CNT_W-1:0]  i_strobe_width,
    input  wire [`LTAT_CNT_W-1:0]  i_cont_strobe_period,
    output reg                     o_trigger_event,
    output reg                     o_busy,
    output reg                     o_integrating,
    output reg                     o_single_strobe,
    output reg                     o_cont_strobe,
    output reg                     o_pulse_error,
    output reg                     o_zero_spectrum,
    output reg                     o_acq_done,
    output reg [`LTAT_CNT_W-1:0]   o_level_pulse_width
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADLY  = 3'h1;
    localparam [2:0] ST_BUSY1 = 3'h2;
    localparam [2:0] ST_INTEG = 3'h3;
    localparam [2:0] ST_BUSY2 = 3'h4;

    // ****************************************
    // Fixed figures
    // ****************************************
    // Busy lengths and pulse minimums in whole microseconds
    localparam [`LTAT_CNT_W-1:0] V1_BUSY1 = `LTAT_V1_BUSY1_US;
    localparam [`LTAT_CNT_W-1:0] V1_BUSY2 = `LTAT_V1_BUSY2_US;
    localparam [`LTAT_CNT_W-1:0] V1_PMIN  = `LTAT_V1_PULSE_MIN_US;
    localparam [`LTAT_CNT_W-1:0] V2_BUSY1 = `LTAT_V2_BUSY1_US;
    localparam [`LTAT_CNT_W-1:0] V2_BUSY2 = `LTAT_V2_BUSY2_US;
    localparam [`LTAT_CNT_W-1:0] V2_PMIN  = `LTAT_V2_PULSE_MIN_US;
    localparam [`LTAT_CNT_W-1:0] ONE      = 24'h000001;
    localparam [`LTAT_CNT_W-1:0] ZERO     = 24'h000000;

    // ****************************************
    // Helpers
    // ****************************************
    function [`LTAT_CNT_W-1:0] pick;
        input                    v;
        input [`LTAT_CNT_W-1:0]  a;
        input [`LTAT_CNT_W-1:0]  b;
        begin
            pick = v ? b : a;
        end
    endfunction

    function [`LTAT_CNT_W-1:0] inc;
        input [`LTAT_CNT_W-1:0]  c;
        begin
            inc = c + ONE;
        end
    endfunction

    reg [2:0]              state_q;
    reg [`LTAT_CNT_W-1:0]  phase_q;
    reg [`LTAT_CNT_W-1:0]  integ_q;
    reg [`LTAT_CNT_W-1:0]  cs_q;
    reg                    trig_d1_q;
    reg                    variant_q;
    wire                   tick;
    wire                   rise;
    wire                   sync;
    wire                   integ_end;

    // ****************************************
    // Edge detect and tick alignment
    // ****************************************
    assign rise      = i_ext_trigger & ~trig_d1_q;
    assign integ_end = (state_q == ST_INTEG) & ~i_ext_trigger;
    // Tick restarts at the event and at integration end, so each busy
    // phase lasts a whole number of microseconds from its own start
    assign sync      = (rise & (state_q == ST_IDLE)) | integ_end;

    ltat_tick u_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_sync  (sync),
        .o_tick  (tick)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q             <= ST_IDLE;
            phase_q             <= ZERO;
            integ_q             <= ZERO;
            cs_q                <= ZERO;
            trig_d1_q           <= 1'b0;
            variant_q           <= 1'b0;
            o_trigger_event     <= 1'b0;
            o_busy              <= 1'b0;
            o_integrating       <= 1'b0;
            o_single_strobe     <= 1'b0;
            o_cont_strobe       <= 1'b0;
            o_pulse_error       <= 1'b0;
            o_zero_spectrum     <= 1'b0;
            o_acq_done          <= 1'b0;
            o_level_pulse_width <= ZERO;
        end else if (i_ce) begin
            trig_d1_q       <= i_ext_trigger;
            o_trigger_event <= 1'b0;
            o_acq_done      <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (rise) begin
                        // Event one cycle after the edge: 100 ns, beyond the 20 to 30 ns latency budget
                        o_trigger_event <= 1'b1;
                        variant_q       <= i_variant;
                        o_busy          <= 1'b1;
                        o_pulse_error   <= 1'b0;
                        o_zero_spectrum <= 1'b0;
                        phase_q         <= ZERO;
                        if (i_acquisition_delay_time == 19'h00000) begin
                            state_q <= ST_BUSY1;
                        end else begin
                            state_q <= ST_ADLY;
                        end
                    end
                end
                ST_ADLY: begin
                    if (tick) begin
                        if (phase_q + ONE >= {5'h00, i_acquisition_delay_time}) begin
                            phase_q <= ZERO;
                            state_q <= ST_BUSY1;
                        end else begin
                            phase_q <= phase_q + ONE;
                        end
                    end
                end
                ST_BUSY1: begin
                    if (tick) begin
                        if (phase_q + ONE >= pick(variant_q, V1_BUSY1, V2_BUSY1)) begin
                            phase_q       <= ZERO;
                            integ_q       <= ZERO;
                            cs_q          <= ZERO;
                            o_integrating <= 1'b1;
                            o_single_strobe <= (i_one_shot_strobe_delay == ZERO)
                                               && (i_strobe_width != ZERO);
                            o_cont_strobe <= (i_cont_strobe_period != ZERO);
                            state_q       <= ST_INTEG;
                        end else begin
                            phase_q <= phase_q + ONE;
                        end
                    end
                end
                ST_INTEG: begin
                    // Integration ends with the trigger level only
                    if (integ_end) begin
                        o_integrating       <= 1'b0;
                        o_single_strobe     <= 1'b0;
                        o_cont_strobe       <= 1'b0;
                        o_level_pulse_width <= integ_q;
                        // Short pulse: spectrum returned as zeros
                        if (integ_q < pick(variant_q, V1_PMIN, V2_PMIN)) begin
                            o_pulse_error   <= 1'b1;
                            o_zero_spectrum <= 1'b1;
                        end
                        phase_q <= ZERO;
                        state_q <= ST_BUSY2;
                    end else if (tick) begin
                        integ_q <= inc(integ_q);
                        // Strobe window measured from integration start
                        if (inc(integ_q) == i_one_shot_strobe_delay) begin
                            o_single_strobe <= (i_strobe_width != ZERO);
                        end else if (inc(integ_q) ==
                                     i_one_shot_strobe_delay + i_strobe_width) begin
                            o_single_strobe <= 1'b0;
                        end
                        // Half-period toggle; final period may be cut short
                        if (i_cont_strobe_period != ZERO) begin
                            if (inc(cs_q) >= i_cont_strobe_period) begin
                                cs_q          <= ZERO;
                                o_cont_strobe <= ~o_cont_strobe;
                            end else begin
                                cs_q <= inc(cs_q);
                            end
                        end
                    end
                end
                ST_BUSY2: begin
                    // Trigger edges are ignored until this phase completes
                    if (tick) begin
                        if (phase_q + ONE >= pick(variant_q, V1_BUSY2, V2_BUSY2)) begin
                            phase_q    <= ZERO;
                            o_busy     <= 1'b0;
                            o_acq_done <= 1'b1;
                            state_q    <= ST_IDLE;
                        end else begin
                            phase_q <= phase_q + ONE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: ltat_regs.vh
`ifndef LTAT_REGS_VH
`define LTAT_REGS_VH

// Clock rate and tick derivation
`define LTAT_CLK_HZ           10000000
`define LTAT_TICK_US          1
`define LTAT_TICK_CYC         ((`LTAT_CLK_HZ / 1000000) * `LTAT_TICK_US)
`define LTAT_TICK_W           4
// Last count of a tick period, LTAT_TICK_CYC - 1 at the tick width
`define LTAT_TICK_LAST        4'h9

// Trigger event latency, ns; latency cycles rounded as a least time
`define LTAT_TRGDLY_MIN_NS    20
`define LTAT_TRGDLY_MAX_NS    30
`define LTAT_CLK_PERIOD_NS    100
`define LTAT_TRGDLY_CYC       1

// Variant 1 figures (us)
`define LTAT_V1_PULSE_MIN_US  24'h000ed8
`define LTAT_V1_PULSE_MAX_US  24'h989680
`define LTAT_V1_BUSY1_US      24'h000e7a
`define LTAT_V1_BUSY2_US      24'h000e7a
// Variant 2 figures (us)
`define LTAT_V2_PULSE_MIN_US  24'h001c20
`define LTAT_V2_PULSE_MAX_US  24'h4c4b40
`define LTAT_V2_BUSY1_US      24'h000006
`define LTAT_V2_BUSY2_US      24'h001371

`define LTAT_ACQDLY_MAX_US    19'h51e8c

// Counter widths
`define LTAT_CNT_W            24
`define LTAT_DLY_W            19

`endif

// File: ltat_src.sv
`timescale 1ns/1ps
// ************
// External level trigger source
// ************
module ltat_src (
    input  logic i_clk,
    output logic o_trig
);
    initial o_trig = 1'b0;
    // Short spans stand for a source breaking the minimum width
    task fire(input int n);
        @(posedge i_clk);
        #1 o_trig = 1'b1;
        repeat (n) @(posedge i_clk);
        #1 o_trig = 1'b0;
    endtask
endmodule

// File: ltat_tick.v
`timescale 1ns/1ps

// ****************************************
// 1 us tick generator
// ****************************************
module ltat_tick (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_ce,
    input  wire i_sync,
    output reg  o_tick
);
`include "ltat_regs.vh"

    reg [`LTAT_TICK_W-1:0] cnt_q;

    // Restart on sync so the first tick of a phase is a full microsecond
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= 4'h0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (i_sync) begin
                cnt_q  <= 4'h0;
                o_tick <= 1'b0;
            end else if (cnt_q == `LTAT_TICK_LAST) begin
                cnt_q  <= 4'h0;
                o_tick <= 1'b1;
            end else begin
                cnt_q  <= cnt_q + 4'h1;
                o_tick <= 1'b0;
            end
        end
    end

endmodule

// File: tb.sv
`timescale 1ns/1ps
`include "ltat_regs.vh"
// ************
// Bench top
// ************
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        var_sel = 1'b1;
    logic        cs_prev = 1'b0;
    logic [18:0] adly = 19'h0;
    logic [23:0] sdly = 24'h0, swid = 24'h0, cper = 24'h0;
    wire         trig, ev, busy, integ, ss, cs, perr, zs, done;
    wire  [23:0] lpw;
    int          fail_count = 0, n_compared = 0;
    int          t_lat, t_start, t_int, t_done, n_ss, n_cs, n_ev, e_int;
    always #50 clk = ~clk;
    ltat_src src_u (.i_clk(clk), .o_trig(trig));
    ltat_core dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_variant(var_sel),
        .i_ext_trigger(trig), .i_acquisition_delay_time(adly), .i_one_shot_strobe_delay(sdly),
        .i_strobe_width(swid), .i_cont_strobe_period(cper), .o_trigger_event(ev), .o_busy(busy),
        .o_integrating(integ), .o_single_strobe(ss), .o_cont_strobe(cs), .o_pulse_error(perr),
        .o_zero_spectrum(zs), .o_acq_done(done), .o_level_pulse_width(lpw));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cyc;
        @(posedge clk);
        #1;
    endtask
    task guard(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            conclude;
        end
    endtask
    // One whole acquisition; a stray trigger is fired into the final busy
    task acquire(input int hold);
        {t_lat, t_start, t_int, t_done, n_ss, n_cs, n_ev} = '0;
        cs_prev = 1'b0;
        fork src_u.fire(hold); join_none
        while (ev !== 1'b1 && t_lat < 8) begin cyc; t_lat++; end
        guard(t_lat, 8);
        while (integ !== 1'b1 && t_start < 400000) begin cyc; t_start++; n_ev += ev; end
        guard(t_start, 400000);
        e_int = perr;
        while (integ === 1'b1 && t_int < 200000) begin
            n_ss += ss;
            n_cs += cs & ~cs_prev;
            cs_prev = cs;
            cyc;
            t_int++;
        end
        guard(t_int, 200000);
        fork src_u.fire(5); join_none
        while (done !== 1'b1 && t_done < 60000) begin cyc; t_done++; n_ev += ev; end
        guard(t_done, 60000);
    endtask
    task t_strobes;
        adly = 19'h3;
        sdly = 24'h2;
        swid = 24'h3;
        cper = 24'h2;
        acquire(300);
        check(t_lat, 2);
        check(t_start >= 88 && t_start <= 92, 1);
        check(t_lat + t_start + t_int >= 299 && t_lat + t_start + t_int <= 303, 1);
        check(lpw >= t_int / 10 - 1 && lpw <= t_int / 10 + 1, 1);
        check(n_ss >= 29 && n_ss <= 31, 1);
        check(n_cs >= 4 && n_cs <= 7, 1);
        check({perr, zs}, 2'h3);
        check(t_done >= 49768 && t_done <= 49772, 1);
        check(n_ev, 0);
        check(busy, 0);
        $display("strobe scenario finished");
    endtask
    task t_no_delay;
        adly = 19'h0;
        swid = 24'h0;
        cper = 24'h0;
        acquire(150);
        check(t_start >= 58 && t_start <= 62, 1);
        check(e_int, 0);
        check(n_ss + n_cs, 0);
        check({perr, zs}, 2'h3);
        $display("no-delay scenario finished");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) cyc;
        t_strobes;
        t_no_delay;
        conclude;
    end
endmodule
bind ltat_core ltat_chk chk_u (.i_clk, .i_rst_n, .i_variant, .i_ext_trigger,
    .i_acquisition_delay_time, .o_trigger_event, .o_busy, .o_integrating, .o_single_strobe,
    .o_cont_strobe, .o_pulse_error, .o_zero_spectrum, .o_acq_done, .o_level_pulse_width);
